// ==== ssp_pkg.sv ====
// ssp_pkg.sv: register map, field layout and reset values of the serial port
`default_nettype none
package ssp_pkg;
  localparam int unsigned DW = 16;           // register data width
  localparam int unsigned AW = 3;            // register address width
  // register word addresses
  localparam logic [AW-1:0] A_CTRL = 3'h0;   // serial_port_control_reg
  localparam logic [AW-1:0] A_BAUD = 3'h1;   // baud_timer_reload_reg
  localparam logic [AW-1:0] A_TX   = 3'h2;   // transmit holding buffer
  localparam logic [AW-1:0] A_RX   = 3'h3;   // receive buffer
  localparam logic [AW-1:0] A_STAT = 3'h4;   // event status, write one clears
  localparam logic [AW-1:0] A_MASK = 3'h5;   // interrupt mask
  // control field positions
  localparam int unsigned CB_WID = 0;        // [3:0] word width minus one
  localparam int unsigned CB_LSB = 4;        // 1: lsb shifted first
  localparam int unsigned CB_PHA = 5;        // clock phase
  localparam int unsigned CB_POL = 6;        // clock idle level
  localparam int unsigned CB_MST = 7;        // 1: master, 0: slave
  localparam int unsigned CB_EN  = 15;       // port_global_enable
  // status field positions
  localparam int unsigned SB_TX   = 0;       // tx buffer taken (sticky)
  localparam int unsigned SB_RX   = 1;       // word received (sticky)
  localparam int unsigned SB_ERR  = 2;       // receive overrun (sticky)
  localparam int unsigned SB_BUSY = 3;       // shifter active
  localparam int unsigned SB_TXF  = 4;       // tx buffer full
  localparam int unsigned SB_RXF  = 5;       // rx buffer full
  // values after reset
  localparam logic [DW-1:0] CTRL_RST = 16'h0007;
  localparam logic [DW-1:0] BAUD_RST = 16'h0001;
  localparam logic [2:0]    MASK_RST = 3'h0;
  localparam logic [2:0]    STAT_RST = 3'h0;
  // master sequencing
  typedef enum {M_IDLE, M_SHIFT} ssp_mst_t;
endpackage
`default_nettype wire

// ==== ssp_shift_if.sv ====
// ssp_shift_if.sv: link between the port control and its shift engine
`timescale 1ns/10ps
`default_nettype none
interface ssp_shift_if;
  logic        start;     // load tx_word and begin a word
  logic        abort;     // drop the word in progress
  logic        lead;      // leading shift clock edge
  logic        trail;     // trailing shift clock edge
  logic        cpha;      // clock phase
  logic        lsb_first; // shift direction
  logic [3:0]  wid;       // width minus one
  logic        sdi;       // serial data in (synchronised)
  logic        sdo;       // serial data out
  logic [15:0] tx_word;   // word to send
  logic [15:0] rx_word;   // word received
  logic        done;      // one-cycle pulse, rx_word valid
  logic        active;    // word in progress
  modport ctl (output start, abort, lead, trail, cpha, lsb_first, wid, sdi,
               tx_word, input sdo, rx_word, done, active);
  modport eng (input start, abort, lead, trail, cpha, lsb_first, wid, sdi,
               tx_word, output sdo, rx_word, done, active);
endinterface
`default_nettype wire

// ==== ssp_baud.sv ====
// ssp_baud.sv: dedicated 16-bit down-counting baud timer with reload
`timescale 1ns/10ps
`default_nettype none
module ssp_baud (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic [15:0] reload,
  output logic      [15:0] count,
  output logic             phase
);
  import ssp_pkg::*;
  logic pre;    // half-rate prescaler
  logic run_d;  // enable seen last cycle
  logic tick;   // timer advance, one cycle in two

  // prescaler only runs while enabled
  always_ff @(posedge core_clk) begin
    if (!resetn || !enable) pre <= 1'b0;
    else pre <= ~pre;
  end
  assign tick = enable & pre;

  always_ff @(posedge core_clk) begin
    if (!resetn) run_d <= 1'b0;
    else run_d <= enable;
  end

  // load on enable, count down, reload at underflow
  always_ff @(posedge core_clk) begin
    if (!resetn) count <= 16'h0000;
    else if (enable && !run_d) count <= reload;
    else if (tick) count <= (count == 16'h0000) ? reload : count - 16'h0001;
  end

  // for a nonzero reload, two phase events per reload+1 ticks (reload 0 gives only underflow): underflow and midway, so a
  // bit lasts 2*(reload+1) core cycles; halves differ by a tick for
  // even reloads
  always_ff @(posedge core_clk) begin
    if (!resetn) phase <= 1'b0;
    else phase <= tick && ((count == 16'h0000) ||
                  (count - 16'h0001 == {1'b0, reload[15:1]}));
  end
endmodule
`default_nettype wire

// ==== ssp_shift.sv ====
// ssp_shift.sv: shift engine, one word of 1 to 16 bits per start
`timescale 1ns/10ps
`default_nettype none
module ssp_shift (
  input wire logic core_clk,
  input wire logic resetn,
  ssp_shift_if.eng sif
);
  import ssp_pkg::*;
  logic [15:0] sreg;   // outgoing bits
  logic [15:0] rreg;   // incoming bits
  logic [4:0]  nbit;   // bits sampled so far
  logic        first;  // no shift edge seen yet
  logic [4:0]  wlen;   // word length
  logic        smp;    // sampling edge
  logic        shf;    // shifting edge

  // right-justify the collected bits for either direction
  function automatic logic [15:0] align(input logic [15:0] r,
                                        input logic [3:0] w,
                                        input logic lsb);
    align = lsb ? (r >> (4'hf - w)) : (r & ~(16'hfffe << w));
  endfunction

  // one incoming bit joins the collected ones at the end it belongs to
  function automatic logic [15:0] shin(input logic [15:0] r,
                                       input logic b,
                                       input logic lsb);
    shin = lsb ? {b, r[15:1]} : {r[14:0], b};
  endfunction

  assign wlen = {1'b0, sif.wid} + 5'h01;
  // phase 0 samples on leading, phase 1 on trailing edge
  assign smp = sif.cpha ? sif.trail : sif.lead;
  assign shf = sif.cpha ? sif.lead : sif.trail;
  assign sif.sdo = sif.lsb_first ? sreg[0] : sreg[sif.wid];

  // data path: load, shift out, sample
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sreg <= 16'h0000;
      rreg <= 16'h0000;
    end else if (sif.start) begin
      sreg <= sif.tx_word;
    end else if (sif.active) begin
      if (smp) rreg <= shin(rreg, sif.sdi, sif.lsb_first);
      // phase 1 presents its first bit without shifting
      if (shf && !(sif.cpha && first))
        sreg <= sif.lsb_first ? (sreg >> 1) : (sreg << 1);
    end
  end

  // control: bit count, end of word, result register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sif.active  <= 1'b0;
      sif.done    <= 1'b0;
      sif.rx_word <= 16'h0000;
      nbit        <= 5'h00;
      first       <= 1'b0;
    end else begin
      sif.done <= 1'b0;
      if (sif.abort) begin
        sif.active <= 1'b0;
      end else if (sif.start) begin
        sif.active <= 1'b1;
        nbit       <= 5'h00;
        first      <= 1'b1;
      end else if (sif.active) begin
        if (smp) nbit <= nbit + 5'h01;
        if (shf) first <= 1'b0;
        // a word ends on the trailing edge after its last sample in phase 0, on the last sample itself in phase 1
        if (sif.trail && ((sif.cpha ? nbit + 5'h01 : nbit) == wlen)) begin
          sif.active  <= 1'b0;
          sif.done    <= 1'b1;
          // phase 1 takes its last bit in this very cycle, either order
          sif.rx_word <= align(sif.cpha ? shin(rreg, sif.sdi, sif.lsb_first)
                                        : rreg, sif.wid, sif.lsb_first);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== ssp_port.sv ====
// ssp_port.sv: synchronous serial port top, registers, pins and interrupts
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ssp_port (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic [ssp_pkg::AW-1:0] addr,
  input  wire logic [ssp_pkg::DW-1:0] wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [ssp_pkg::DW-1:0] rdata,
  input  wire logic                   sclk_in,
  output logic                        sclk_out,
  output logic                        sclk_oe,
  input  wire logic                   mosi_in,
  output logic                        mosi_out,
  output logic                        mosi_oe,
  input  wire logic                   miso_in,
  output logic                        miso_out,
  output logic                        miso_oe,
  input  wire logic                   ssel_n_in,
  output logic                        ssel_n_out,
  output logic                        ssel_n_oe,
  output logic                        irq_tx,
  output logic                        irq_rx,
  output logic                        irq_err,
  output logic                        irq
);
  import ssp_pkg::*;

  // register state
  logic [DW-1:0] ctrl;      // serial_port_control_reg
  logic [DW-1:0] reload;    // baud_timer_reload_reg
  logic [DW-1:0] tx_hold;   // transmit holding buffer
  logic          tx_full;   // holding buffer has a word
  logic [DW-1:0] rx_hold;   // receive buffer
  logic          rx_full;   // receive buffer unread
  logic [2:0]    status;    // sticky events
  logic [2:0]    mask;      // interrupt enables
  logic [2:0]    ev_set;    // events this cycle
  logic [DW-1:0] bcount;    // running baud timer value
  logic          phase;     // baud phase event

  // decoded control fields
  logic en;                 // port_global_enable
  logic master;             // master mode
  logic cpol;               // idle clock level
  assign en     = ctrl[CB_EN];
  assign master = ctrl[CB_MST];
  assign cpol   = ctrl[CB_POL];

  // bus strobes
  logic wr_ctrl;
  logic wr_baud;
  logic wr_tx;
  logic wr_stat;
  logic wr_mask;
  logic rd_rx;
  assign wr_ctrl = wr && (addr == A_CTRL);
  assign wr_baud = wr && (addr == A_BAUD);
  assign wr_tx   = wr && (addr == A_TX);
  assign wr_stat = wr && (addr == A_STAT);
  assign wr_mask = wr && (addr == A_MASK);
  assign rd_rx   = rd && (addr == A_RX);

  // pin synchronisers: sync1 feeds sync2 only, sclk_d follows sync2
  logic [3:0] sync1;        // first stage {ssel, miso, mosi, sclk}
  logic [3:0] sync2;        // second stage, safe to use
  logic       sclk_d;       // previous synchronised shift clock
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync1  <= 4'hf;
      sync2  <= 4'hf;
      sclk_d <= 1'b0;
    end else begin
      sync1  <= {ssel_n_in, miso_in, mosi_in, sclk_in};
      sync2  <= sync1;
      sclk_d <= sync2[0];
    end
  end

  // slave side view of the pins
  logic s_sel;              // slave selected
  logic s_sel_d;            // selection last cycle
  logic s_lead;             // leading edge seen on external clock
  logic s_trail;            // trailing edge seen on external clock
  assign s_sel   = ~sync2[3];
  assign s_lead  = s_sel && (sync2[0] != sclk_d) && (sclk_d == cpol);
  assign s_trail = s_sel && (sync2[0] != sclk_d) && (sclk_d != cpol);

  always_ff @(posedge core_clk) begin
    if (!resetn) s_sel_d <= 1'b0;
    else s_sel_d <= s_sel;
  end

  // baud timer runs only while the port is enabled
  ssp_baud u_baud (
    .core_clk (core_clk),
    .resetn   (resetn),
    .enable   (en),
    .reload   (reload),
    .count    (bcount),
    .phase    (phase)
  );

  // shift engine
  ssp_shift_if sif ();
  ssp_shift u_shift (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sif      (sif)
  );

  // master sequencer
  ssp_mst_t mst;            // master state
  logic     m_go;           // master may start a word
  logic     s_go;           // slave selection began
  assign m_go = en && master && (mst == M_IDLE) && tx_full && phase;
  assign s_go = en && !master && s_sel && !s_sel_d;

  // master waits for a phase event so the first bit gets a full half
  // bit of setup before the first clock edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mst <= M_IDLE;
    end else begin
      case (mst)
        M_IDLE: begin
          if (m_go) mst <= M_SHIFT;
        end
        M_SHIFT: begin
          if (!en || sif.done) mst <= M_IDLE;
        end
        default: begin
          mst <= M_IDLE;
        end
      endcase
    end
  end

  // master shift clock toggles on each phase event while shifting
  always_ff @(posedge core_clk) begin
    if (!resetn) sclk_out <= 1'b0;
    else if (mst == M_SHIFT && sif.active && phase) sclk_out <= ~sclk_out;
    else if (mst == M_IDLE) sclk_out <= cpol; // idle level
  end

  // engine drive: edges from own timer or from the external master
  assign sif.start     = m_go || s_go;
  assign sif.abort     = !en || (!master && !s_sel && sif.active);
  assign sif.lead      = master ? (mst == M_SHIFT && phase &&
                                   sclk_out == cpol) : s_lead;
  assign sif.trail     = master ? (mst == M_SHIFT && phase &&
                                   sclk_out != cpol) : s_trail;
  assign sif.cpha      = ctrl[CB_PHA];
  assign sif.lsb_first = ctrl[CB_LSB];
  assign sif.wid       = ctrl[CB_WID +: 4];
  // an unloaded slave answers with zeros
  assign sif.tx_word   = tx_full ? tx_hold : 16'h0000;
  assign sif.sdi       = master ? sync2[2] : sync2[1];

  // pins: master drives clock, data out and select; a slave drives
  // its data line only while selected so others may share it
  assign mosi_out   = sif.sdo;
  assign miso_out   = sif.sdo;
  assign sclk_oe    = en && master;
  assign mosi_oe    = en && master;
  assign ssel_n_oe  = en && master;
  assign ssel_n_out = (mst != M_SHIFT);
  assign miso_oe    = en && !master && s_sel;

  // control register
  always_ff @(posedge core_clk) begin
    if (!resetn) ctrl <= CTRL_RST;
    else if (wr_ctrl) ctrl <= wdata;
  end

  // reload accepted only while disabled
  always_ff @(posedge core_clk) begin
    if (!resetn) reload <= BAUD_RST;
    else if (wr_baud && !en) reload <= wdata;
  end

  // transmit holding buffer: the engine takes it at word start, so the
  // next word can be queued while this one shifts
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_hold <= 16'h0000;
      tx_full <= 1'b0;
    end else if (wr_tx) begin
      tx_hold <= wdata;
      tx_full <= 1'b1;
    end else if (sif.start || !en) begin
      tx_full <= 1'b0;
    end
  end

  // receive buffer: a completed word wins over a read in the same
  // cycle so that no word is silently lost
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_hold <= 16'h0000;
      rx_full <= 1'b0;
    end else if (sif.done) begin
      rx_hold <= sif.rx_word;
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  // events: buffer taken, word in, overrun on an unread buffer
  assign ev_set[SB_TX]  = sif.start && tx_full;
  assign ev_set[SB_RX]  = sif.done;
  assign ev_set[SB_ERR] = sif.done && rx_full && !rd_rx;

  // sticky status, write one clears, a new event wins over its clear
  always_ff @(posedge core_clk) begin
    if (!resetn) status <= STAT_RST;
    else if (wr_stat) status <= (status & ~wdata[2:0]) | ev_set;
    else status <= status | ev_set;
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (!resetn) mask <= MASK_RST;
    else if (wr_mask) mask <= wdata[2:0];
  end

  // three separate requests plus their sum, all levels
  assign irq_tx  = status[SB_TX] & mask[SB_TX];
  assign irq_rx  = status[SB_RX] & mask[SB_RX];
  assign irq_err = status[SB_ERR] & mask[SB_ERR];
  assign irq     = irq_tx | irq_rx | irq_err;

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        A_CTRL: rdata <= ctrl;
        // live count while enabled, reload while not
        A_BAUD: rdata <= en ? bcount : reload;
        A_TX:   rdata <= tx_hold;
        A_RX:   rdata <= rx_hold;
        A_STAT: rdata <= {10'h000, rx_full, tx_full, sif.active, status};
        A_MASK: rdata <= {13'h0000, mask};
        default: rdata <= 16'h0000; // unmapped reads as zero
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // checks next to the logic they guard
  property p_baud_live;
    @(posedge core_clk) disable iff (!resetn)
      (rd && addr == A_BAUD && en) |=> (rdata == $past(bcount));
  endproperty
  a_baud_live: assert property (p_baud_live)
    else $error("baud read while enabled is not the timer count");

  property p_baud_reload;
    @(posedge core_clk) disable iff (!resetn)
      (rd && addr == A_BAUD && !en) |=> (rdata == $past(reload));
  endproperty
  a_baud_reload: assert property (p_baud_reload)
    else $error("baud read while disabled is not the reload");

  property p_reload_lock;
    @(posedge core_clk) disable iff (!resetn)
      (wr_baud && en) |=> $stable(reload);
  endproperty
  a_reload_lock: assert property (p_reload_lock)
    else $error("reload changed while enabled");

  property p_timer_stop;
    @(posedge core_clk) disable iff (!resetn)
      (!en && $past(!en)) |-> ($stable(bcount) && !phase);
  endproperty
  a_timer_stop: assert property (p_timer_stop)
    else $error("baud timer moved while disabled");

  property p_half_rate;
    @(posedge core_clk) disable iff (!resetn)
      phase |=> !phase;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("phase events faster than half core rate");

  // a disable right after underflow freezes the count, so en must last
  property p_underflow;
    @(posedge core_clk) disable iff (!resetn)
      (en && $past(en) && bcount == 16'h0000 && reload != 16'h0000) ##1 en
        |-> ##[0:1] (bcount == reload);
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("timer did not reload after underflow");

  property p_rx_event;
    @(posedge core_clk) disable iff (!resetn)
      sif.done |=> (status[SB_RX] && rx_full && rx_hold == $past(sif.rx_word));
  endproperty
  a_rx_event: assert property (p_rx_event)
    else $error("received word not buffered and flagged");

  property p_overrun;
    @(posedge core_clk) disable iff (!resetn)
      (sif.done && rx_full && !rd_rx) |=> status[SB_ERR];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_tx_take;
    @(posedge core_clk) disable iff (!resetn)
      (sif.start && tx_full && !wr_tx) |=> (!tx_full && status[SB_TX]);
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("holding buffer not released at word start");

  property p_idle_clk;
    @(posedge core_clk) disable iff (!resetn)
      (en && master && mst == M_IDLE && $past(mst == M_IDLE) &&
       $stable(cpol)) |-> (sclk_out == cpol);
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("master clock not at idle level");

  property p_slave_quiet;
    @(posedge core_clk) disable iff (!resetn)
      !master |-> (!sclk_oe && !mosi_oe && !ssel_n_oe);
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("slave drives master pins");
endmodule
`default_nettype wire

// ==== ssp_spi_slave.sv ====
// ssp_spi_slave.sv: behavioural spi slave, mode 0 or 3, msb first
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_slave (
  input  wire logic        sclk,
  input  wire logic        ssel_n,
  input  wire logic        mosi,
  input  wire logic        cpha,
  input  wire logic [15:0] reply,
  output logic             miso,
  output logic      [15:0] got
);
  logic [15:0] sh = 16'h0;    // outgoing shift register
  logic        skip = 1'b0;   // phase 1: first fall only presents a bit
  // a released line shows the inverted bit, so stale data cannot pass
  assign miso = ssel_n ? ~sh[15] : sh[15];
  // select loads the reply, first bit is out before the first edge
  always @(negedge ssel_n) begin
    sh = reply;
    got = 16'h0;
    skip = cpha;
  end
  // sample on the rising edge, shift on the falling edge
  always @(posedge sclk) if (!ssel_n) got = {got[14:0], mosi};
  // phase 1 presents its first bit at select, so its first fall is idle
  always @(negedge sclk) begin
    if (!ssel_n && skip) skip = 1'b0;
    else if (!ssel_n) sh = {sh[14:0], 1'b0};
  end
endmodule
`default_nettype wire

// ==== sync_serial_port_with_baud_gen_test.sv ====
// sync_serial_port_with_baud_gen_test.sv: register level port testbench
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_with_baud_gen_test;
  import ssp_pkg::*;
  logic          core_clk, resetn, wr, rd;   // clock, reset, strobes
  logic [AW-1:0] addr;                       // register address
  logic [DW-1:0] wdata, rdata, reply, got, v; // bus and partner data
  logic          sclk_out, sclk_oe, mosi_out, miso_in, ssel_n_out;
  logic          irq_tx, irq_rx, irq_err, irq; // interrupt lines
  logic          mosi_oe, miso_oe, ssel_n_oe, cph; // enables, partner phase
  int            error_cnt, n_tests, per;    // counters, bit period
  realtime       t_rise;                     // last shift clock rise

  ssp_port i_ssp_port (.core_clk(core_clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sclk_in(1'b0),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(1'b0),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(),
    .miso_oe(miso_oe), .ssel_n_in(1'b1), .ssel_n_out(ssel_n_out),
    .ssel_n_oe(ssel_n_oe), .irq_tx(irq_tx), .irq_rx(irq_rx),
    .irq_err(irq_err), .irq(irq));
  ssp_spi_slave i_ssp_spi_slave (.sclk(sclk_out), .ssel_n(ssel_n_out),
    .mosi(mosi_out), .cpha(cph), .reply(reply), .miso(miso_in), .got(got));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // rise to rise of the shift clock, in core cycles
  always @(posedge sclk_out) begin
    per = int'(($realtime - t_rise) / 25.0);
    t_rise = $realtime;
  end
  // a hang is cut short well beyond the longest frame sequence
  initial begin
    #(25.0 * 20000);
    error_cnt++;
    tally_and_finish();
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    @(negedge core_clk); // let the write settle before outputs are looked at
  endtask
  // read data stand only in the cycle after the strobe
  task automatic brd(input logic [AW-1:0] a);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    v = rdata;
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    brd(a);
    chk(v, e);
  endtask
  // one word as master; bounded wait for select to fall and rise
  task automatic xfer(input logic [DW-1:0] c, t, r);
    int k;
    k = 0;
    reply = r;
    cph = c[CB_PHA];
    bw(A_CTRL, c);
    bw(A_TX, t);
    while (ssel_n_out !== 1'b0 && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    while (ssel_n_out !== 1'b1 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 400) begin
      error_cnt++;
      $display("unexpected at %0t: frame never ended", $time);
    end
    repeat (3) @(posedge core_clk);
  endtask
  function automatic logic [15:0] rev(input logic [15:0] x);
    for (int i = 0; i < 16; i++) rev[i] = x[15-i];
  endfunction

  initial begin
    resetn = 1'b0;
    {wr, rd, cph, addr, wdata, reply} = '0;
    {error_cnt, n_tests, per} = '0;
    t_rise = 0.0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(A_CTRL, CTRL_RST);
    rchk(A_BAUD, BAUD_RST);
    rchk(A_STAT, 16'h0000);
    rchk(A_MASK, 16'h0000);
    bw(3'h7, 16'hffff);
    rchk(3'h6, 16'h0000);
    bw(A_BAUD, 16'hffff);
    rchk(A_BAUD, 16'hffff);
    bw(A_BAUD, 16'h0004);
    bw(A_MASK, 16'h0007);
    // 8 bit, msb first, mode 0: bit time is 2*(4+1) cycles
    xfer(16'h8087, 16'h00a5, 16'h3c00);
    chk(got, 16'h00a5);
    chk(16'(per), 16'd10);
    rchk(A_STAT, 16'h0023);
    chk({15'h0, irq_rx}, 16'h1);
    rchk(A_RX, 16'h003c);
    // live count while enabled never exceeds the reload
    brd(A_BAUD);
    chk({15'h0, v <= 16'h4}, 16'h1);
    bw(A_BAUD, 16'h0009);
    // 16 bit, lsb first
    xfer(16'h809f, 16'h1234, 16'hc350);
    chk(got, rev(16'h1234));
    rchk(A_RX, rev(16'hc350));
    // 8 bit, lsb first, mode 3: data change on the fall, sample on rise
    xfer(16'h80f7, 16'h0035, 16'h9600);
    chk(got, 16'h00ac);
    rchk(A_RX, 16'h0069);
    // two words unread: receive overrun
    xfer(16'h809f, 16'h8001, 16'h0f0f);
    xfer(16'h809f, 16'h7ffe, 16'hf0f0);
    rchk(A_STAT, 16'h0027);
    chk({15'h0, irq_err}, 16'h1);
    bw(A_MASK, 16'h0001);
    chk({13'h0, irq_tx, irq_err, irq}, 16'h5);
    bw(A_STAT, 16'h0007);
    rchk(A_STAT, 16'h0020);
    chk({15'h0, irq}, 16'h0);
    // the timer stops, reload survives the ignored write
    bw(A_CTRL, 16'h0087);
    chk({13'h0, mosi_oe, ssel_n_oe, miso_oe}, 16'h0);
    rchk(A_BAUD, 16'h0004);
    bw(A_CTRL, 16'h80c7);
    repeat (4) @(posedge core_clk);
    chk({14'h0, sclk_out, sclk_oe}, 16'h3);
    chk({13'h0, mosi_oe, ssel_n_oe, miso_oe}, 16'h6);
    tally_and_finish();
  end
endmodule
`default_nettype wire
